/* File: rtl/cpbd_core_port.sv */
`timescale 1ns/100ps
`default_nettype none
module cpbd_core_port
  import cpbd_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  // core side
  input  wire logic                   next_write_in,
  input  wire logic [CPBD_ADDR_W-1:0] next_addr_in,
  input  wire logic [CPBD_DATA_W-1:0] wdata_in,
  input  wire logic                   next_byte_word_n_in,
  input  wire logic                   next_lock_in,
  input  wire logic                   next_opcode_fetch_n_in,
  input  wire logic                   privileged_in,
  input  wire logic                   cp_start_in,
  input  wire logic                   cp_cond_pass_in,
  input  wire logic [CPBD_DATA_W-1:0] cp_instr_in,
  input  wire logic                   cp_reg_xfer_in,
  input  wire logic                   irq_in,
  output logic                        cp_commit_out,
  output logic                        cp_undef_trap_out,
  output logic                        cp_retry_out,
  output logic                        cp_done_out,
  output logic                        cp_busy_out,
  output logic [CPBD_DATA_W-1:0]      rdata_out,
  // pins
  input  wire logic                   address_bus_enable_in,
  input  wire logic                   data_bus_enable_in,
  input  wire logic                   test_bus_enable_in,
  input  wire logic                   bus_input_enable_n_in,
  input  wire logic [CPBD_DATA_W-1:0] data_in,
  output logic [CPBD_DATA_W-1:0]      data_out,
  output logic                        data_oe_out,
  output logic [CPBD_ADDR_W-1:0]      addr_out,
  output logic                        addr_oe_out,
  output logic                        write_not_read_out,
  output logic                        byte_word_n_out,
  output logic                        lock_out,
  output logic                        opcode_fetch_n_out,
  output logic                        ctrl_oe_out,
  output logic                        privilege_indicator_n_out,
  output logic                        priv_oe_out,
  output logic                        core_drive_indication_n_out,
  output logic                        memory_request_n_out,
  output logic                        sequential_cycle_out,
  output logic                        coproc_instr_n_out,
  input  wire logic                   coproc_absent_in,
  input  wire logic                   coproc_busy_in
);
  logic       phase;
  logic       write_cycle;
  logic [2:0] en_s1;
  logic [2:0] en_s2;
  logic       ab_en;
  logic       db_en;
  logic       tb_en;
  logic       nen_s1;
  logic       nen_s2;
  logic [1:0] hs_s1;
  logic [1:0] hs_s2;
  logic       coproc_absent;
  logic       coproc_busy;
  logic [CPBD_DATA_W-1:0] din_s1;
  logic [CPBD_DATA_W-1:0] din_s2;
  cpbd_hs_t   hs;
  logic       drive_ok;

  // bit CPBD_COPROC_BIT marks a coprocessor opcode; undefined encodings are still offered on the strobe
  function automatic logic cpbd_is_coproc(input logic [CPBD_DATA_W-1:0] i);
    return i[CPBD_COPROC_BIT];
  endfunction

  // enables and handshake come from pins: two flops each
  always_ff @(posedge clk_in) begin
    en_s1  <= {address_bus_enable_in, data_bus_enable_in, test_bus_enable_in};
    en_s2  <= en_s1;
    nen_s1 <= bus_input_enable_n_in;
    nen_s2 <= nen_s1;
    hs_s1  <= {coproc_absent_in, coproc_busy_in};
    hs_s2  <= hs_s1;
    din_s1 <= data_in;
    din_s2 <= din_s1;
  end
  // test enable is pure gating, never captured into a scan-style hold
  assign tb_en    = en_s2[0];
  assign ab_en    = en_s2[2] & tb_en;
  assign db_en    = en_s2[1] & tb_en;
  assign coproc_absent      = hs_s2[1];
  assign coproc_busy      = hs_s2[0];
  assign drive_ok = db_en & ~nen_s2;

  // two-phase cycle: one clk per phase
  always_ff @(posedge clk_in) begin
    if (sys_rst_in)
      phase <= CPBD_RST_PHASE;
    else
      phase <= ~phase;
  end

  // address and control forecast in phase 2 for the next cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      write_not_read_out <= 1'b0;
      addr_out           <= '0;
      byte_word_n_out    <= 1'b1;
      lock_out           <= 1'b0;
      opcode_fetch_n_out <= 1'b1;
      write_cycle        <= 1'b0;
    end else if (phase == CPBD_PH1) begin
      write_not_read_out <= next_write_in;
      addr_out           <= next_addr_in;
      byte_word_n_out    <= next_byte_word_n_in;
      lock_out           <= next_lock_in;
      opcode_fetch_n_out <= next_opcode_fetch_n_in;
    end else begin
      write_cycle <= write_not_read_out;
    end
  end

  // drive indication low in write phase 1, released at the end of phase 1
  always_ff @(posedge clk_in) begin
    if (sys_rst_in)
      core_drive_indication_n_out <= 1'b1;
    else if (phase == CPBD_PH2)
      core_drive_indication_n_out <= ~write_not_read_out;
    else
      core_drive_indication_n_out <= 1'b1;
  end

  // data drive waits for the outside enables; off at once at cycle end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      data_out    <= '0;
      data_oe_out <= 1'b0;
      rdata_out   <= '0;
    end else begin
      data_out    <= wdata_in;
      data_oe_out <= ~core_drive_indication_n_out & write_cycle
                     & drive_ok & (phase == CPBD_PH1);
      rdata_out   <= din_s2;
    end
  end

  // output enable groups per pin class
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      addr_oe_out <= 1'b0;
      ctrl_oe_out <= 1'b0;
      priv_oe_out <= 1'b0;
      privilege_indicator_n_out <= 1'b1;
    end else begin
      addr_oe_out <= ab_en & db_en;
      ctrl_oe_out <= ab_en;
      priv_oe_out <= db_en;
      privilege_indicator_n_out <= ~privileged_in;
    end
  end

  // coprocessor handshake, evaluated on every clk, in both phases
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hs                 <= CPBD_IDLE;
      coproc_instr_n_out <= 1'b1;
      cp_commit_out      <= 1'b0;
      cp_undef_trap_out  <= 1'b0;
      cp_retry_out       <= 1'b0;
      cp_done_out        <= 1'b0;
      cp_busy_out        <= 1'b0;
    end else begin
      cp_commit_out     <= 1'b0;
      cp_undef_trap_out <= 1'b0;
      cp_retry_out      <= 1'b0;
      cp_done_out       <= 1'b0;
      unique case (hs)
        CPBD_IDLE: if (cp_start_in && cp_cond_pass_in) begin
          coproc_instr_n_out <= 1'b0;
          cp_busy_out        <= 1'b1;
          hs                 <= CPBD_OFFER;
        end
        CPBD_OFFER, CPBD_WAIT: begin
          if (irq_in) begin
            coproc_instr_n_out <= 1'b1;
            cp_retry_out       <= 1'b1;
            cp_busy_out        <= 1'b0;
            hs                 <= CPBD_IDLE;
          end else if (!coproc_absent && !coproc_busy) begin
            cp_commit_out      <= 1'b1;
            coproc_instr_n_out <= 1'b1;
            hs                 <= cpbd_is_coproc(cp_instr_in) && !cp_reg_xfer_in
                                  ? CPBD_IDLE : CPBD_XFER;
            cp_done_out        <= !cp_reg_xfer_in;
            cp_busy_out        <= cp_reg_xfer_in;
          end else if (coproc_absent && coproc_busy && hs == CPBD_OFFER) begin
            coproc_instr_n_out <= 1'b1;
            cp_undef_trap_out  <= 1'b1;
            cp_busy_out        <= 1'b0;
            hs                 <= CPBD_IDLE;
          end else if (!coproc_absent) begin
            hs <= CPBD_WAIT;
          end
        end
        CPBD_XFER: begin
          cp_done_out <= 1'b1;
          cp_busy_out <= 1'b0;
          hs          <= CPBD_IDLE;
        end
        default: hs <= CPBD_IDLE;
      endcase
    end
  end

  // register transfer: request and sequential both high
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      memory_request_n_out <= 1'b1;
      sequential_cycle_out <= 1'b0;
    end else begin
      memory_request_n_out <= cp_reg_xfer_in | next_opcode_fetch_n_in;
      sequential_cycle_out <= cp_reg_xfer_in;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/cpbd_pkg.sv */
package cpbd_pkg;
  localparam int          CPBD_DATA_W    = 32;
  localparam int          CPBD_ADDR_W    = 32;
  localparam int          CPBD_CPNUM_W   = 4;
  localparam int          CPBD_CPNUM_LSB = 8;
  localparam int          CPBD_NUM_CP    = 16;
  localparam int          CPBD_COPROC_BIT = 27;
  localparam logic        CPBD_PH1       = 1'b0;
  localparam logic        CPBD_PH2       = 1'b1;
  localparam logic        CPBD_RST_PHASE = 1'b0;

  typedef enum logic [2:0] {
    CPBD_IDLE,
    CPBD_OFFER,
    CPBD_WAIT,
    CPBD_XFER
  } cpbd_hs_t;
endpackage

/* File: sim/cpbd_core_port_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module cpbd_core_port_assertions (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic cp_start_in,
  input wire logic cp_cond_pass_in,
  input wire logic cp_commit_out,
  input wire logic cp_undef_trap_out,
  input wire logic cp_done_out,
  input wire logic data_oe_out,
  input wire logic addr_oe_out,
  input wire logic ctrl_oe_out,
  input wire logic priv_oe_out,
  input wire logic core_drive_indication_n_out,
  input wire logic write_not_read_out,
  input wire logic coproc_instr_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_data_gated: assert property (data_oe_out |-> priv_oe_out)
    else $error("data driven with data enable off");
  a_addr_group: assert property (addr_oe_out |-> ctrl_oe_out && priv_oe_out)
    else $error("address enable outside its group");
  a_drive_announced: assert property ($rose(data_oe_out)
    |-> $past(!core_drive_indication_n_out))
    else $error("drive without indication");
  a_dir_first: assert property ($fell(core_drive_indication_n_out)
    |-> write_not_read_out)
    else $error("indication without write direction");
  a_drive_ends: assert property ($rose(core_drive_indication_n_out)
    |=> !data_oe_out)
    else $error("drive kept after write");
  a_strobe_cause: assert property ($fell(coproc_instr_n_out)
    |-> $past(cp_start_in && cp_cond_pass_in))
    else $error("strobe without passed start");
  a_trap_offered: assert property (cp_undef_trap_out
    |-> $past(!coproc_instr_n_out))
    else $error("trap without strobe");
  a_done_follows: assert property (cp_commit_out |-> ##[0:2] cp_done_out)
    else $error("commit not completed");
  a_commit_release: assert property (cp_commit_out |-> coproc_instr_n_out)
    else $error("strobe held after commit");
  c_commit: cover property (cp_commit_out);
  c_trap: cover property (cp_undef_trap_out);
  c_drive: cover property ($rose(data_oe_out));
endmodule
bind cpbd_core_port cpbd_core_port_assertions u_cpbd_core_port_assertions (
  .clk_in, .sys_rst_in, .cp_start_in, .cp_cond_pass_in, .cp_commit_out,
  .cp_undef_trap_out, .cp_done_out, .data_oe_out, .addr_oe_out, .ctrl_oe_out,
  .priv_oe_out, .core_drive_indication_n_out, .write_not_read_out,
  .coproc_instr_n_out);
`default_nettype wire

/* File: sim/cpbd_coproc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cpbd_coproc_model
  import cpbd_pkg::*;
#(parameter logic [3:0] NUM = 4'h5, parameter int WAIT = 12)
(
  input  wire logic                   clk_in,
  input  wire logic [CPBD_DATA_W-1:0] instr_in,
  input  wire logic                   armed_in,
  input  wire logic                   fetch_n_in,
  output logic                        absent_out,
  output logic                        busy_out
);
  int cnt;
  logic [CPBD_DATA_W-1:0] pipe = '0;
  // private copy follows opcode fetches only
  always_ff @(posedge clk_in) begin
    if (!fetch_n_in)
      pipe <= instr_in;
  end
  // claim only our own number on a real coprocessor opcode
  wire logic mine = armed_in && pipe[CPBD_COPROC_BIT] &&
    pipe[CPBD_CPNUM_LSB+:CPBD_CPNUM_W] == NUM;
  // busy count; armed ahead since the core syncs the lines
  always_ff @(posedge clk_in) begin
    cnt <= mine ? cnt + 1 : 0;
  end
  assign absent_out = !mine;
  assign busy_out = !(mine && cnt >= WAIT);
endmodule
`default_nettype wire

/* File: sim/coprocessor_handshake_and_bus_drive_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module coprocessor_handshake_and_bus_drive_tb;
  import cpbd_pkg::*;
  logic clk_in = 0, sys_rst_in = 1, nw = 0, st = 0, cp = 1, irq = 0, arm = 0;
  logic abe = 1, dbe = 1, test_bus_enable = 1, nen = 0, cmt, trp, rty, doe, aoe, coe;
  logic poe, ind_n, wnr, inn, pres, busy, dn, sq, opc, opf = 1;
  logic [31:0] ins = 0, dout, rd;
  int n_fail = 0, num_checks = 0;
  cpbd_core_port u_cpbd_core_port (.clk_in, .sys_rst_in, .next_write_in(nw),
    .next_addr_in(32'h0), .wdata_in(ins), .next_byte_word_n_in(1'h1),
    .next_lock_in(1'h0), .next_opcode_fetch_n_in(opf), .privileged_in(nw),
    .cp_start_in(st), .cp_cond_pass_in(cp), .cp_instr_in(ins),
    .cp_reg_xfer_in(ins[0]), .irq_in(irq), .cp_commit_out(cmt),
    .cp_undef_trap_out(trp), .cp_retry_out(rty), .cp_done_out(dn),
    .cp_busy_out(), .rdata_out(rd), .address_bus_enable_in(abe),
    .data_bus_enable_in(dbe), .test_bus_enable_in(test_bus_enable),
    .bus_input_enable_n_in(nen), .data_in(ins), .data_out(dout),
    .data_oe_out(doe), .addr_out(), .addr_oe_out(aoe),
    .write_not_read_out(wnr), .byte_word_n_out(), .lock_out(),
    .opcode_fetch_n_out(opc), .ctrl_oe_out(coe),
    .privilege_indicator_n_out(),
    .priv_oe_out(poe), .core_drive_indication_n_out(ind_n),
    .memory_request_n_out(), .sequential_cycle_out(sq),
    .coproc_instr_n_out(inn), .coproc_absent_in(pres), .coproc_busy_in(busy));
  cpbd_coproc_model u_cpbd_coproc_model (.clk_in, .instr_in(ins),
    .armed_in(arm), .fetch_n_in(opc), .absent_out(pres), .busy_out(busy));
  always #5 clk_in = ~clk_in;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // every enable combination against the three output groups
  task automatic t_oe();
    for (int i = 0; i < 8; i++) begin
      {abe, dbe, test_bus_enable} = i[2:0];
      cyc(5);
      chk("addr_oe", abe & dbe & test_bus_enable, aoe);
      chk("ctrl_oe", abe & test_bus_enable, coe);
      chk("priv_oe", dbe & test_bus_enable, poe);
    end
    $display("enable test done");
  endtask
  task automatic t_write(input logic en);
    int k;
    ins = 32'hA5C30F96;
    nw = 1;
    cyc(2);
    nw = 0;
    k = 0;
    while (ind_n !== 1'h0 && k < 8) begin
      cyc(1);
      k++;
    end
    chk("direction", 1'h1, wnr);
    chk("indication", 1'h0, ind_n);
    cyc(1);
    chk("data_oe", en, doe);
    if (en) chk("data", ins, dout);
    cyc(4);
    chk("data_oe_end", 1'h0, doe);
    chk("rdata", ins, rd);
    $display("write test done");
  endtask
  task automatic t_cp(input logic [31:0] i, input logic a, q, c,
      input logic [2:0] ex);
    int k;
    ins = i;
    // fetch the opcode so the coprocessor copy holds it
    opf = 0;
    cyc(2);
    opf = 1;
    arm = a;
    irq = q;
    cp = c;
    cyc(3);
    st = 1;
    cyc(1);
    st = 0;
    chk("strobe", !c, inn);
    k = 0;
    while ({cmt, trp, rty} === 3'h0 && k < 40) begin
      cyc(1);
      k++;
    end
    chk("outcome", ex, {cmt, trp, rty});
    chk("strobe_end", 1'h1, inn);
    if (ex == 3'h4) begin
      chk("done", !i[0], dn);
      chk("seq", i[0], sq);
      cyc(1);
      chk("done_xfer", i[0], dn);
    end
    arm = 0;
    irq = 0;
    cp = 1;
    cyc(6);
    $display("coprocessor test done");
  endtask
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    cyc(16);
    sys_rst_in = 0;
    t_oe();
    t_write(1);
    nen = 1;
    t_write(0);
    nen = 0;
    dbe = 0;
    t_write(0);
    dbe = 1;
    t_cp(32'h08000500, 1, 0, 1, 3'h4);
    t_cp(32'h08000700, 1, 0, 1, 3'h2);
    t_cp(32'h00000500, 1, 0, 1, 3'h2);
    t_cp(32'h08000500, 1, 1, 1, 3'h1);
    t_cp(32'h08000500, 1, 0, 1, 3'h4);
    t_cp(32'h08000501, 1, 0, 1, 3'h4);
    t_cp(32'h08000500, 0, 0, 0, 3'h0);
    end_sim();
  end
endmodule
`default_nettype wire
